// File: hw/flash_self_program_sequencer.sv
// Flash self-program sequencer: table read/write, block erase and program
// Contract
// - Each table read fetches one byte at the pointer into the latch
// - Table instructions may step the pointer per their mode
// - Pointer bit zero picks low or high byte of the word
// - Erase clears one whole 64-byte block, nothing smaller or larger
// - Erase block chosen by pointer bits 21..6; bits 5..0 ignored
// - No erase or program begins without the unlock sequence
// - Core is stalled during a long write
// - Internal timer ends each long write, about 2 ms
// - Long write ends on timer expiry with no host action
// - Programming always works on a 64-byte block
// - 64 holding registers; table write loads one from the latch
// - Table write touches only holding registers, no stall
// - Holding registers return to FFh on reset and after programming
// - FFh holding byte leaves flash byte untouched; only clears bits
// - Partial loading allowed; unloaded bytes stay unaltered
// - Start bit only set by software; hardware clears it at end
// - Completion sets the sticky complete flag until software clears
// - Error flag set on reset mid-cycle or improper write attempt
// - Erase select clears itself when an erase finishes
`timescale 1ns/1ps
module flash_self_program_sequencer #(
  parameter int unsigned LONG_WRITE_CYCLES =
    flash_seq_pkg::LONG_WRITE_CYCLES
) (
  // Clock, reset, enable
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Table instructions from the core
  input wire logic tbl_rd_i,
  input wire logic tbl_wr_i,
  input wire logic [1:0] tbl_mode_i,
  input wire logic ptr_load_i,
  input wire logic [21:0] ptr_load_val_i,
  input wire logic latch_load_i,
  input wire logic [7:0] latch_load_val_i,
  // Control register and unlock key port
  input wire logic ctrl_wr_i,
  input wire logic [7:0] ctrl_wdata_i,
  input wire logic key_wr_i,
  input wire logic [7:0] key_wdata_i,
  input wire logic complete_clr_i,
  // Core-visible state
  output logic [21:0] table_pointer_o,
  output logic [7:0] table_latch_o,
  output logic [7:0] ctrl_o,
  output logic [7:0] key_rdata_o,
  output logic write_complete_flag_o,
  output logic core_stall_o,
  // Flash array
  output logic flash_rd_o,
  output logic flash_erase_o,
  output logic flash_prog_o,
  output logic [21:0] flash_addr_o,
  output logic [7:0] flash_wdata_o,
  input wire logic [15:0] flash_rdata_i
);
  typedef enum logic [1:0] {st_idle, st_read, st_prog, st_wait} seq_state_e;

  function automatic logic [21:0] ptr_step(input logic [21:0] p,
                                           input logic up);
    // Only the low 21 bits move; the top bit selects config space
    ptr_step = {p[21], up ? p[20:0] + 21'h000001 : p[20:0] - 21'h000001};
  endfunction

  seq_state_e state, next_state;
  logic [7:0] hold [0:63];
  logic pgm_sel;
  logic cfg_sel;
  logic erase_sel;
  logic err_flag;
  logic write_enable_bit;
  logic start;
  logic rd_lsb;
  logic op_erase;
  logic [5:0] prog_idx;
  logic unlocked;
  logic timer_done;

  flash_seq_pkg::ptr_mode_e mode;
  assign mode = flash_seq_pkg::ptr_mode_e'(tbl_mode_i);

  // Request decode in idle: read beats write beats control; key writes are accepted alongside any of them
  wire idle = state == st_idle;
  wire rd_go = idle && tbl_rd_i;
  wire wr_go = idle && tbl_wr_i && !tbl_rd_i;
  wire ctl_go = idle && ctrl_wr_i && !tbl_rd_i && !tbl_wr_i;
  wire key_go = idle && key_wr_i;

  wire [21:0] ptr_inc = ptr_step(table_pointer_o, 1'b1);
  wire [21:0] ptr_dec = ptr_step(table_pointer_o, 1'b0);
  wire [21:0] eff_ptr =
    (mode == flash_seq_pkg::PTR_PRE_INC) ? ptr_inc : table_pointer_o;
  wire [21:0] next_ptr =
    (mode == flash_seq_pkg::PTR_KEEP) ? table_pointer_o :
    (mode == flash_seq_pkg::PTR_POST_DEC) ? ptr_dec : ptr_inc;

  // Start decode
  wire start_req = ctl_go && ctrl_wdata_i[flash_seq_pkg::CTL_START];
  wire start_ok = start_req && unlocked
    && ctrl_wdata_i[flash_seq_pkg::CTL_WRITE_ENABLE_BIT]
    && ctrl_wdata_i[flash_seq_pkg::CTL_PGM]
    && !ctrl_wdata_i[flash_seq_pkg::CTL_CFG];
  wire start_erase = start_ok && ctrl_wdata_i[flash_seq_pkg::CTL_ERASE];
  wire start_prog = start_ok && !ctrl_wdata_i[flash_seq_pkg::CTL_ERASE];

  wire in_prog = state == st_prog;
  wire last_byte = prog_idx == flash_seq_pkg::BLK_LAST;
  wire hold_skip = hold[prog_idx] == flash_seq_pkg::HOLD_RESET;
  wire timer_go = start_erase || (in_prog && last_byte);
  wire lw_end = state == st_wait && timer_done;
  wire [21:6] blk_base = table_pointer_o[21:6];
  wire [21:0] next_faddr =
    rd_go ? eff_ptr :
    in_prog ? {blk_base, prog_idx} : {blk_base, 6'h00};
  wire [7:0] rd_byte = rd_lsb ? flash_rdata_i[15:8]
                              : flash_rdata_i[7:0];

  always_comb begin
    next_state = state;
    case (state)
      st_idle: begin
        if (rd_go) begin
          next_state = st_read;
        end else if (start_erase) begin
          next_state = st_wait;
        end else if (start_prog) begin
          next_state = st_prog;
        end
      end
      st_read: next_state = st_idle;
      st_prog: next_state = last_byte ? st_wait : st_prog;
      st_wait: next_state = timer_done ? st_idle : st_wait;
      default: next_state = st_idle;
    endcase
  end

  unlock_key_guard u_guard (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .key_wr_i(key_go),
    .key_wdata_i(key_wdata_i),
    .consume_i(ctl_go),
    .unlocked_o(unlocked)
  );

  long_write_timer #(.CYCLES(LONG_WRITE_CYCLES)) u_timer (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .start_i(timer_go),
    .done_o(timer_done)
  );

  // Sequencer state and core stall
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= st_idle;
      core_stall_o <= 1'b0;
    end else if (ce_i) begin
      state <= next_state;
      core_stall_o <= next_state != st_idle;
    end
  end

  // Table pointer and latch
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      table_pointer_o <= '0;
      table_latch_o <= '0;
      rd_lsb <= 1'b0;
    end else if (ce_i) begin
      if (rd_go || wr_go) begin
        table_pointer_o <= next_ptr;
      end else if (idle && ptr_load_i) begin
        table_pointer_o <= ptr_load_val_i;
      end
      if (rd_go) begin
        rd_lsb <= eff_ptr[0];
      end
      if (state == st_read) begin
        table_latch_o <= rd_byte;
      end else if (idle && latch_load_i) begin
        table_latch_o <= latch_load_val_i;
      end
    end
  end

  // Flash array strobes; a read takes the word in the same cycle the strobe is high
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flash_rd_o <= 1'b0;
      flash_erase_o <= 1'b0;
      flash_prog_o <= 1'b0;
      flash_addr_o <= '0;
      flash_wdata_o <= flash_seq_pkg::HOLD_RESET;
    end else if (ce_i) begin
      flash_rd_o <= rd_go;
      flash_erase_o <= start_erase;
      flash_prog_o <= in_prog && !hold_skip;
      flash_addr_o <= next_faddr;
      flash_wdata_o <= hold[prog_idx];
    end
  end

  // Holding registers
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < flash_seq_pkg::BLK_BYTES; i++) begin
        hold[i] <= flash_seq_pkg::HOLD_RESET;
      end
    end else if (ce_i) begin
      if (lw_end && !op_erase) begin
        for (int i = 0; i < flash_seq_pkg::BLK_BYTES; i++) begin
          hold[i] <= flash_seq_pkg::HOLD_RESET;
        end
      end else if (wr_go) begin
        hold[eff_ptr[5:0]] <= table_latch_o;
      end
    end
  end

  // Program walk index and operation kind
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prog_idx <= '0;
      op_erase <= 1'b0;
    end else if (ce_i) begin
      if (start_ok) begin
        prog_idx <= '0;
        op_erase <= start_erase;
      end else if (in_prog) begin
        prog_idx <= prog_idx + 6'h01;
      end
    end
  end

  // Control bits
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pgm_sel <= flash_seq_pkg::PGM_RESET;
      cfg_sel <= flash_seq_pkg::CFG_RESET;
      erase_sel <= flash_seq_pkg::ERASE_RESET;
      // Reads as set after reset, so a cut-short cycle stays visible
      err_flag <= flash_seq_pkg::ERR_RESET;
      write_enable_bit <= flash_seq_pkg::WRITE_ENABLE_BIT_RESET;
      start <= flash_seq_pkg::START_RESET;
    end else if (ce_i) begin
      if (ctl_go) begin
        pgm_sel <= ctrl_wdata_i[flash_seq_pkg::CTL_PGM];
        cfg_sel <= ctrl_wdata_i[flash_seq_pkg::CTL_CFG];
        erase_sel <= ctrl_wdata_i[flash_seq_pkg::CTL_ERASE];
        write_enable_bit <= ctrl_wdata_i[flash_seq_pkg::CTL_WRITE_ENABLE_BIT];
        // Any start attempt raises the flag; a clean finish, or a control write with start and bit 3 clear, drops it
        err_flag <= start_req
          || ctrl_wdata_i[flash_seq_pkg::CTL_ERR];
        start <= start_ok;
      end else if (lw_end) begin
        start <= 1'b0;
        err_flag <= 1'b0;
        if (op_erase) begin
          erase_sel <= 1'b0;
        end
      end
    end
  end

  // Sticky completion flag; a new completion beats a clear
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      write_complete_flag_o <= 1'b0;
    end else if (ce_i) begin
      write_complete_flag_o <= lw_end
        || (write_complete_flag_o && !complete_clr_i);
    end
  end

  assign ctrl_o = {pgm_sel, cfg_sel, 1'b0, erase_sel, err_flag, write_enable_bit,
                   start, 1'b0};
  assign key_rdata_o = flash_seq_pkg::KEY_READ_VALUE;

  // Checking helpers
  logic [flash_seq_pkg::CNT_W-1:0] wait_cnt;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_cnt <= '0;
    end else if (ce_i) begin
      wait_cnt <= timer_go ? '0 : wait_cnt + 20'h00001;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  chk_read_fetch: assert property (
    ce_i && rd_go |=> flash_rd_o && flash_addr_o == $past(eff_ptr))
    else $error("table read did not fetch at pointer");
  chk_read_byte: assert property (
    ce_i && state == st_read |=> table_latch_o == $past(rd_byte))
    else $error("latch not loaded with selected byte");
  chk_ptr_post_inc: assert property (
    ce_i && rd_go && mode == flash_seq_pkg::PTR_POST_INC
    |=> table_pointer_o == $past(ptr_inc))
    else $error("pointer did not post-increment");
  chk_erase_block: assert property (
    flash_erase_o |-> flash_addr_o[5:0] == 6'h00 && core_stall_o)
    else $error("erase address not block aligned");
  chk_start_guard: assert property (
    ce_i && start_req && !unlocked |=> !ctrl_o[1] && !core_stall_o)
    else $error("long write started without unlock");
  chk_stall_long: assert property (
    state == st_prog || state == st_wait |-> core_stall_o)
    else $error("core not stalled in long write");
  chk_timer_len: assert property (
    lw_end |-> wait_cnt == flash_seq_pkg::CNT_W'(LONG_WRITE_CYCLES))
    else $error("long write length wrong");
  chk_end_flags: assert property (
    ce_i && lw_end |=> !ctrl_o[1] && write_complete_flag_o && !err_flag)
    else $error("completion did not update flags");
  chk_hold_reload: assert property (
    ce_i && lw_end && !op_erase
    |=> hold[0] == flash_seq_pkg::HOLD_RESET
        && hold[63] == flash_seq_pkg::HOLD_RESET)
    else $error("holding registers not restored");
  chk_prog_skip: assert property (
    flash_prog_o |-> flash_wdata_o != flash_seq_pkg::HOLD_RESET)
    else $error("erased byte value was programmed");
  chk_table_write_instruction_short: assert property (
    ce_i && wr_go |=> !core_stall_o && !flash_prog_o && !flash_erase_o)
    else $error("table write touched the array");

  cov_read: cover property (ce_i && state == st_read);
  cov_erase_done: cover property (lw_end && op_erase);
  cov_prog_done: cover property (lw_end && !op_erase);
  cov_bad_start: cover property (start_req && !start_ok);
endmodule

// File: hw/flash_seq_pkg.sv
// Shared constants for the flash self-program sequencer
package flash_seq_pkg;
  localparam int PTR_W = 22;
  localparam int BLK_IDX_W = 6;
  localparam int BLK_BYTES = 64;
  localparam logic [5:0] BLK_LAST = 6'h3f;
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;
  localparam logic [7:0] KEY_READ_VALUE = 8'h00;
  localparam logic [7:0] HOLD_RESET = 8'hff;
  // Control register bit positions
  localparam int CTL_PGM = 7;
  localparam int CTL_CFG = 6;
  localparam int CTL_ERASE = 4;
  localparam int CTL_ERR = 3;
  localparam int CTL_WRITE_ENABLE_BIT = 2;
  localparam int CTL_START = 1;
  // Control register reset values
  localparam logic PGM_RESET = 1'b0;
  localparam logic CFG_RESET = 1'b0;
  localparam logic ERASE_RESET = 1'b0;
  localparam logic ERR_RESET = 1'b1;
  localparam logic WRITE_ENABLE_BIT_RESET = 1'b0;
  localparam logic START_RESET = 1'b0;
  // Long write time
  localparam int CNT_W = 20;
  localparam int LONG_WRITE_MS = 2;
  localparam int CLK_FREQ_KHZ = 200_000;
  localparam int unsigned LONG_WRITE_CYCLES = LONG_WRITE_MS * CLK_FREQ_KHZ;
  typedef enum logic [1:0] {
    PTR_KEEP,
    PTR_POST_INC,
    PTR_POST_DEC,
    PTR_PRE_INC
  } ptr_mode_e;
endpackage

// File: hw/unlock_key_guard.sv
// Two-key unlock sequence tracker
`timescale 1ns/1ps
module unlock_key_guard (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Key writes and consumption
  input wire logic key_wr_i,
  input wire logic [7:0] key_wdata_i,
  input wire logic consume_i,
  // Status
  output logic unlocked_o
);
  typedef enum logic [1:0] {ul_idle, ul_first, ul_armed} unlock_state_e;
  unlock_state_e state, next_state;
  wire key_first = key_wdata_i == flash_seq_pkg::KEY_FIRST;
  wire key_second = key_wdata_i == flash_seq_pkg::KEY_SECOND;

  always_comb begin
    next_state = state;
    if (key_wr_i) begin
      case (state)
        ul_idle: next_state = key_first ? ul_first : ul_idle;
        ul_first: next_state = key_second ? ul_armed : ul_idle;
        default: next_state = ul_idle;
      endcase
    end else if (consume_i) begin
      // A control write spends the unlock unless a key write lands in the same cycle; the key write then decides the state
      next_state = ul_idle;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= ul_idle;
    end else if (ce_i) begin
      state <= next_state;
    end
  end

  assign unlocked_o = state == ul_armed;

  chk_key_break: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ce_i && key_wr_i && !key_second |=> !unlocked_o)
    else $error("unlock survived a wrong key write");
endmodule

// File: hw/long_write_timer.sv
// Self-timed long write timer
`timescale 1ns/1ps
module long_write_timer #(
  parameter int unsigned CYCLES = flash_seq_pkg::LONG_WRITE_CYCLES
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Control
  input wire logic start_i,
  output logic done_o
);
  localparam logic [flash_seq_pkg::CNT_W-1:0] LOAD =
    flash_seq_pkg::CNT_W'(CYCLES);
  localparam logic [flash_seq_pkg::CNT_W-1:0] ONE = 20'h00001;
  logic [flash_seq_pkg::CNT_W-1:0] cnt;
  wire at_last = cnt == ONE;
  wire running = cnt != '0;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= '0;
      done_o <= 1'b0;
    end else if (ce_i) begin
      if (start_i) begin
        cnt <= LOAD;
      end else if (running) begin
        cnt <= cnt - ONE;
      end
      done_o <= at_last && !start_i;
    end
  end
endmodule

// File: testbench/flash_array_model.sv
// Behavioural flash array that answers the sequencer's strobes
`timescale 1ns/1ps
module flash_array_model (
  // Clock
  input wire logic mclk_i,
  // Strobes and data from the sequencer
  input wire logic rd_i,
  input wire logic erase_i,
  input wire logic prog_i,
  input wire logic [21:0] addr_i,
  input wire logic [7:0] wdata_i,
  // Read word
  output logic [15:0] rdata_o
);
  // Only the low 256 bytes are modelled, enough for four blocks
  logic [7:0] mem [0:255];
  logic [15:0] junk = 16'h5aa5;
  logic [7:0] base;
  assign base = {addr_i[7:1], 1'b0};
  // Outside a read the bus toggles, so a stale word never passes
  assign rdata_o = rd_i ? {mem[base | 8'h01], mem[base]} : junk;
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'ha5;
    end
  end
  always @(posedge mclk_i) begin
    junk <= ~junk;
    if (erase_i) begin
      for (int i = 0; i < 64; i++) begin
        mem[{addr_i[7:6], 6'(i)}] <= 8'hff;
      end
    end
    if (prog_i) begin
      // Programming can only clear bits
      mem[addr_i[7:0]] <= mem[addr_i[7:0]] & wdata_i;
    end
  end
endmodule

// File: testbench/test_flash_self_program_sequencer.sv
// Self-checking testbench for the flash self-program sequencer
`timescale 1ns/1ps
module test_flash_self_program_sequencer;
  localparam int unsigned LW = 20;
  logic mclk_i, rst_n_i, ce_i, tbl_rd_i, tbl_wr_i, ptr_load_i;
  logic latch_load_i, ctrl_wr_i, key_wr_i, complete_clr_i;
  logic [1:0] tbl_mode_i;
  logic [21:0] ptr_load_val_i, table_pointer_o, flash_addr_o;
  logic [7:0] latch_load_val_i, ctrl_wdata_i, key_wdata_i;
  logic [7:0] table_latch_o, ctrl_o, key_rdata_o, flash_wdata_o;
  logic write_complete_flag_o, core_stall_o, flash_rd_o;
  logic flash_erase_o, flash_prog_o;
  logic [15:0] flash_rdata_i;
  int mismatches = 0;
  int n_checks = 0;

  flash_self_program_sequencer #(.LONG_WRITE_CYCLES(LW)) dut_u (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .tbl_rd_i(tbl_rd_i), .tbl_wr_i(tbl_wr_i), .tbl_mode_i(tbl_mode_i),
    .ptr_load_i(ptr_load_i), .ptr_load_val_i(ptr_load_val_i),
    .latch_load_i(latch_load_i), .latch_load_val_i(latch_load_val_i),
    .ctrl_wr_i(ctrl_wr_i), .ctrl_wdata_i(ctrl_wdata_i),
    .key_wr_i(key_wr_i), .key_wdata_i(key_wdata_i),
    .complete_clr_i(complete_clr_i), .table_pointer_o(table_pointer_o),
    .table_latch_o(table_latch_o), .ctrl_o(ctrl_o),
    .key_rdata_o(key_rdata_o),
    .write_complete_flag_o(write_complete_flag_o),
    .core_stall_o(core_stall_o), .flash_rd_o(flash_rd_o),
    .flash_erase_o(flash_erase_o), .flash_prog_o(flash_prog_o),
    .flash_addr_o(flash_addr_o), .flash_wdata_o(flash_wdata_o),
    .flash_rdata_i(flash_rdata_i)
  );

  flash_array_model flash_u (
    .mclk_i(mclk_i), .rd_i(flash_rd_o), .erase_i(flash_erase_o),
    .prog_i(flash_prog_o), .addr_i(flash_addr_o),
    .wdata_i(flash_wdata_o), .rdata_o(flash_rdata_i)
  );

  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end

  function automatic logic [7:0] iv(input logic [7:0] a);
    return a ^ 8'ha5;
  endfunction

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic cmp(input string what, input logic [21:0] exp,
                     input logic [21:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Counts the cycles the core stays stalled, bounded against a hang
  task automatic wait_idle(output int cyc);
    cyc = 0;
    while (core_stall_o !== 1'b0 && cyc < 2000) begin
      @(negedge mclk_i);
      cyc++;
    end
    if (cyc >= 2000) begin
      mismatches++;
      $display("[FAIL] stall expected 0 seen %b", core_stall_o);
      finish_test();
    end
  endtask

  task automatic key(input logic [7:0] v);
    @(negedge mclk_i);
    key_wr_i = 1'b1;
    key_wdata_i = v;
    @(negedge mclk_i);
    key_wr_i = 1'b0;
  endtask

  task automatic ctrl(input logic [7:0] v);
    @(negedge mclk_i);
    ctrl_wr_i = 1'b1;
    ctrl_wdata_i = v;
    @(negedge mclk_i);
    ctrl_wr_i = 1'b0;
  endtask

  task automatic set_ptr(input logic [21:0] v);
    @(negedge mclk_i);
    ptr_load_i = 1'b1;
    ptr_load_val_i = v;
    @(negedge mclk_i);
    ptr_load_i = 1'b0;
  endtask

  task automatic tread(input logic [1:0] m, input logic [7:0] exp,
                       input logic [21:0] exp_ptr);
    int cyc;
    @(negedge mclk_i);
    tbl_rd_i = 1'b1;
    tbl_mode_i = m;
    @(negedge mclk_i);
    tbl_rd_i = 1'b0;
    wait_idle(cyc);
    cmp("latch", 22'(exp), 22'(table_latch_o));
    cmp("pointer", exp_ptr, table_pointer_o);
  endtask

  task automatic chk_rd(input logic [21:0] a, input logic [7:0] exp);
    set_ptr(a);
    tread(flash_seq_pkg::PTR_KEEP, exp, a);
  endtask

  task automatic twrite(input logic [1:0] m, input logic [7:0] d);
    @(negedge mclk_i);
    latch_load_i = 1'b1;
    latch_load_val_i = d;
    @(negedge mclk_i);
    latch_load_i = 1'b0;
    tbl_wr_i = 1'b1;
    tbl_mode_i = m;
    @(negedge mclk_i);
    tbl_wr_i = 1'b0;
    cmp("wr_stall", 22'd0, 22'(core_stall_o));
  endtask

  // Unlock, start, and check the stall lasts the self-timed length
  task automatic long_op(input logic [7:0] v, input int lo);
    int cyc;
    key(8'h55);
    key(8'haa);
    ctrl(v);
    wait_idle(cyc);
    cmp("stall_len", 22'd1, 22'(cyc >= lo && cyc <= lo + 2));
  endtask

  task automatic refuse(input logic [7:0] k1, k2, v, exp);
    key(k1);
    key(k2);
    ctrl(v);
    @(negedge mclk_i);
    cmp("ref_stall", 22'd0, 22'(core_stall_o));
    cmp("ref_ctrl", 22'(exp), 22'(ctrl_o));
  endtask

  initial begin
    {tbl_rd_i, tbl_wr_i, ptr_load_i, latch_load_i} = 4'h0;
    {ctrl_wr_i, key_wr_i, complete_clr_i} = 3'h0;
    tbl_mode_i = 2'h0;
    ptr_load_val_i = 22'h000000;
    {latch_load_val_i, ctrl_wdata_i, key_wdata_i} = 24'h000000;
    ce_i = 1'b1;
    rst_n_i = 1'b0;
    repeat (12) @(negedge mclk_i);
    rst_n_i = 1'b1;
    cmp("ctrl_rst", 22'h08, 22'(ctrl_o));
    cmp("key_rd", 22'h00, 22'(key_rdata_o));
    cmp("flag_rst", 22'd0, 22'(write_complete_flag_o));
    $display("test reset done");
    set_ptr(22'h000010);
    tread(flash_seq_pkg::PTR_POST_INC, iv(8'h10), 22'h11);
    tread(flash_seq_pkg::PTR_PRE_INC, iv(8'h12), 22'h12);
    tread(flash_seq_pkg::PTR_POST_DEC, iv(8'h12), 22'h11);
    tread(flash_seq_pkg::PTR_KEEP, iv(8'h11), 22'h11);
    set_ptr(22'h3fffff);
    tread(flash_seq_pkg::PTR_POST_INC, iv(8'hff), 22'h200000);
    $display("test table read done");
    set_ptr(22'h000047);
    long_op(8'h96, LW);
    cmp("ctrl_erase", 22'h84, 22'(ctrl_o));
    cmp("flag_set", 22'd1, 22'(write_complete_flag_o));
    @(negedge mclk_i);
    complete_clr_i = 1'b1;
    @(negedge mclk_i);
    complete_clr_i = 1'b0;
    cmp("flag_clr", 22'd0, 22'(write_complete_flag_o));
    chk_rd(22'h00003f, iv(8'h3f));
    chk_rd(22'h000040, 8'hff);
    chk_rd(22'h00007f, 8'hff);
    chk_rd(22'h000080, iv(8'h80));
    $display("test erase done");
    set_ptr(22'h000040);
    twrite(flash_seq_pkg::PTR_POST_INC, 8'h12);
    twrite(flash_seq_pkg::PTR_POST_INC, 8'h34);
    cmp("wr_ptr", 22'h42, table_pointer_o);
    chk_rd(22'h000040, 8'hff);
    set_ptr(22'h000040);
    long_op(8'h86, 64 + LW);
    cmp("ctrl_prog", 22'h84, 22'(ctrl_o));
    chk_rd(22'h000040, 8'h12);
    chk_rd(22'h000041, 8'h34);
    chk_rd(22'h000042, 8'hff);
    set_ptr(22'h000040);
    twrite(flash_seq_pkg::PTR_KEEP, 8'h0f);
    long_op(8'h86, 64 + LW);
    chk_rd(22'h000040, 8'h02);
    chk_rd(22'h000041, 8'h34);
    $display("test program done");
    refuse(8'h00, 8'h00, 8'h86, 8'h8c);
    refuse(8'h12, 8'haa, 8'h86, 8'h8c);
    refuse(8'h55, 8'haa, 8'h82, 8'h88);
    refuse(8'h55, 8'haa, 8'hc6, 8'hcc);
    chk_rd(22'h000040, 8'h02);
    $display("test refusal done");
    set_ptr(22'h000080);
    key(8'h55);
    key(8'haa);
    ctrl(8'h96);
    repeat (3) @(negedge mclk_i);
    rst_n_i = 1'b0;
    @(negedge mclk_i);
    rst_n_i = 1'b1;
    cmp("ctrl_cut", 22'h08, 22'(ctrl_o));
    cmp("stall_cut", 22'd0, 22'(core_stall_o));
    $display("test reset cut done");
    finish_test();
  end
endmodule
